// ===== logic/fracn_pll_ctrl_map.vh
// Register map, field positions, reset values and counts for the
// fractional-N divider control block. Definitions only.
`ifndef FRACN_PLL_CTRL_MAP_VH
`define FRACN_PLL_CTRL_MAP_VH

// Register byte addresses (word aligned)
`define REG_CTRL_ADDR      12'h000
`define REG_INTDIV_ADDR    12'h004
`define REG_PRIFRAC_ADDR   12'h008
`define REG_AUXFRAC_ADDR   12'h00C
`define REG_AUXMOD_ADDR    12'h010
`define REG_REFCFG_ADDR    12'h014
`define REG_TRIGGER_ADDR   12'h018
`define REG_STATUS_ADDR    12'h01C
`define REG_REVISION_ADDR  12'h020
`define REG_THRESH_ADDR    12'h024
`define REG_NACT_ADDR      12'h028
`define REG_VCOSEL_ADDR    12'h02C

// Control register fields
`define CTRL_REFDIFF_BIT   6
`define CTRL_AUTOCAL_BIT   0
`define CTRL_SDMOFF_BIT    1
`define CTRL_RESET         32'h0000_0001

// Reference configuration fields
`define REFCFG_RCNT_LSB    0
`define REFCFG_DBL_BIT     5
`define REFCFG_HALF_BIT    6
`define REFCFG_CP_LSB      8
`define REFCFG_RESET       32'h0000_0000

// Field widths and limits
`define INT_W              16
`define PRIFRAC_W          25
`define AUX_W              14
`define CP_W               4
`define INT_RESET          16'h0064
`define AUXMOD_RESET       14'h0002
`define AUXMOD_MIN         14'h0002
`define REV_DEFAULT        8'h5A

// Band selection: 4 cores, 256 bands, 16 clocks per step, 11 steps
`define SEL_STEP_CLKS      5'h10
`define SEL_STEPS          4'hB
`define SEL_CORE_STEPS     4'h3

`endif

// ===== logic/fracn_pll_ctrl.v
// Divider control for a fractional-N synthesizer: APB register file,
// double-buffered divider settings except the integer part, reference counter and VCO select.
// Assumes APB is synchronous to clock; refPulse is one cycle per ref edge.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fracn_pll_ctrl_map.vh"

// What this block does
// - Reference mode bit one means differential input, zero means positive input only.
// - Feedback divides by integer plus fractions over fixed 2^25 modulus.
// - Primary fraction accepts zero up to modulus minus one.
// - Auxiliary fraction 14 bits any value; auxiliary modulus 2..16383.
// - Phase detector clock is ref times doubler over count and half-divide.
// - Reference counter divides by 1 through 32.
// - Both fractions zero gives integer-N operation.
// - Buffered settings apply only after a later trigger write.
// - Selection picks one of four cores and 256 bands.
// - Trigger with autocal runs selection, tuning node tied to reference.
// - Selection clocked by reference counter output; loop resumes after.
// - Read-only revision field lets software tell revisions apart.
module fracn_pll_ctrl #(
  parameter [7:0] REVISION = `REV_DEFAULT // Arbitrary value
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Reference input edge, one cycle per reference period
  input  wire        refPulse,
  // Comparator result from band search: 1 means VCO too slow
  input  wire        vcoSlow,
  // Analog controls
  output reg         refDiffMode,
  output reg         sdmDisable,
  output reg         phaseDetectorClk,
  output reg         tuningNodeToRef,
  output reg         intMode,
  output reg  [15:0] intActive,
  output reg  [24:0] primaryFracActive,
  output reg  [13:0] auxFracActive,
  output reg  [13:0] auxModActive,
  output reg  [3:0]  cpCurrent,
  output reg  [1:0]  vcoCore,
  output reg  [7:0]  vcoBand
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CORE = 4'b0010;
  localparam [3:0] ST_BAND = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg [31:0] ctrl_q;
  reg [15:0] int_q;
  reg [24:0] primaryFrac_q;
  reg [13:0] auxFrac_q;
  reg [13:0] auxMod_q;
  reg [31:0] refCfg_q;
  reg [2:0]  thresh_q;
  reg        dblActive_q;
  reg        halfActive_q;
  reg [4:0]  rcntActive_q;
  reg [4:0]  rcnt_q;
  reg        halfTog_q;
  reg        rcntTick_q;
  reg [3:0]  state_q;
  reg [4:0]  clkCnt_q;
  reg [3:0]  step_q;
  reg [7:0]  bandBit_q;
  reg        dblPhase_q;

  // Bus qualifiers: a write lands in the access cycle, where pready stands
  wire        access;
  wire        wrEn;
  wire        trigWr;
  // Fields of the live control word and the buffered reference word
  wire        refDiffField;
  wire        sdmOffField;
  wire        autoCalField;
  wire [4:0]  rcntField;
  wire        dblField;
  wire        halfField;
  wire [3:0]  cpField;
  wire        fracZero;

  assign access       = psel & penable;
  assign wrEn         = access & pwrite;
  assign trigWr       = wrEn & (paddr == `REG_TRIGGER_ADDR);
  assign refDiffField = ctrl_q[`CTRL_REFDIFF_BIT];
  assign sdmOffField  = ctrl_q[`CTRL_SDMOFF_BIT];
  assign autoCalField = ctrl_q[`CTRL_AUTOCAL_BIT];
  assign rcntField    = refCfg_q[`REFCFG_RCNT_LSB +: 5];
  assign dblField     = refCfg_q[`REFCFG_DBL_BIT];
  assign halfField    = refCfg_q[`REFCFG_HALF_BIT];
  assign cpField      = refCfg_q[`REFCFG_CP_LSB +: `CP_W];
  assign fracZero     = (primaryFrac_q == 25'h0000000) && (auxFrac_q == 14'h0000);

  function mapped;
    input [11:0] a;
    begin
      mapped = (a <= `REG_VCOSEL_ADDR) && (a[1:0] == 2'b00);
    end
  endfunction

  // APB: zero-wait answer in the access cycle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q   <= `CTRL_RESET;
      int_q    <= `INT_RESET;
      primaryFrac_q <= 25'h0000000;
      auxFrac_q     <= 14'h0000;
      auxMod_q      <= `AUXMOD_RESET;
      refCfg_q <= `REFCFG_RESET;
      thresh_q <= 3'h0;
    end else if (wrEn) begin
      case (paddr)
        `REG_CTRL_ADDR:   ctrl_q   <= pwdata;
        `REG_INTDIV_ADDR: int_q    <= pwdata[15:0];
        `REG_PRIFRAC_ADDR: primaryFrac_q <= pwdata[24:0];
        `REG_AUXFRAC_ADDR: auxFrac_q     <= pwdata[13:0];
        // A modulus below the floor would stall the modulator, so clamp it
        `REG_AUXMOD_ADDR:
          auxMod_q <= (pwdata[13:0] < `AUXMOD_MIN) ? `AUXMOD_MIN : pwdata[13:0];
        `REG_REFCFG_ADDR: refCfg_q <= pwdata;
        `REG_THRESH_ADDR: thresh_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `REG_CTRL_ADDR:     prdata <= ctrl_q;
          `REG_INTDIV_ADDR:   prdata <= {16'h0000, int_q};
          `REG_PRIFRAC_ADDR:  prdata <= {7'h00, primaryFrac_q};
          `REG_AUXFRAC_ADDR:  prdata <= {18'h00000, auxFrac_q};
          `REG_AUXMOD_ADDR:   prdata <= {18'h00000, auxMod_q};
          `REG_REFCFG_ADDR:   prdata <= refCfg_q;
          `REG_STATUS_ADDR:   prdata <= {27'h0000000, intMode, tuningNodeToRef, state_q[3:1]};
          `REG_REVISION_ADDR: prdata <= {24'h000000, REVISION};
          `REG_THRESH_ADDR:   prdata <= {29'h00000000, thresh_q};
          `REG_NACT_ADDR:     prdata <= {16'h0000, intActive};
          `REG_VCOSEL_ADDR:   prdata <= {22'h000000, vcoCore, vcoBand};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Unbuffered controls follow the register one edge later
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      refDiffMode <= 1'b0;
      sdmDisable  <= 1'b0;
    end else begin
      refDiffMode <= refDiffField;
      sdmDisable  <= sdmOffField;
    end
  end

  // Double buffer: all fraction, modulus, pump current and reference counter settings move together on the trigger write
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      intActive    <= `INT_RESET;
      primaryFracActive <= 25'h0000000;
      auxFracActive     <= 14'h0000;
      auxModActive      <= `AUXMOD_RESET;
      cpCurrent    <= 4'h0;
      dblActive_q  <= 1'b0;
      halfActive_q <= 1'b0;
      rcntActive_q <= 5'h00;
      intMode      <= 1'b1;
    end else begin
      // Integer part is not buffered: it follows its register directly
      intActive <= int_q;
      // One edge moves every buffered field, but the unbuffered integer part can pair with old fractions
      if (trigWr) begin
        primaryFracActive <= primaryFrac_q;
        auxFracActive     <= auxFrac_q;
        auxModActive      <= auxMod_q;
        cpCurrent         <= cpField;
        dblActive_q       <= dblField;
        halfActive_q      <= halfField;
        rcntActive_q      <= rcntField;
        intMode           <= fracZero;
      end
    end
  end

  // Reference path: doubler takes both pulse phases, count field 0 means 32
  wire refEdge = refPulse | (dblActive_q & dblPhase_q);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dblPhase_q       <= 1'b0;
      rcnt_q           <= 5'h00;
      halfTog_q        <= 1'b0;
      rcntTick_q       <= 1'b0;
      phaseDetectorClk <= 1'b0;
    end else begin
      dblPhase_q <= refPulse;
      rcntTick_q <= 1'b0;
      if (refEdge) begin
        if (rcnt_q == rcntActive_q - 5'h01) begin
          rcnt_q    <= 5'h00;
          halfTog_q <= ~halfTog_q;
          if (~halfActive_q | halfTog_q) begin
            rcntTick_q <= 1'b1;
          end
        end else begin
          rcnt_q <= rcnt_q + 5'h01;
        end
      end
      phaseDetectorClk <= rcntTick_q;
    end
  end

  // Band search: core steps then band bits, each step SEL_STEP_CLKS ticks
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q         <= ST_IDLE;
      clkCnt_q        <= 5'h00;
      step_q          <= 4'h0;
      bandBit_q       <= 8'h80;
      vcoCore         <= 2'h0;
      vcoBand         <= 8'h80;
      tuningNodeToRef <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // A trigger during a search updates settings but does not restart it
          if (trigWr & autoCalField) begin
            state_q         <= ST_CORE;
            tuningNodeToRef <= 1'b1;
            clkCnt_q        <= 5'h00;
            step_q          <= 4'h0;
            vcoCore         <= 2'h0;
            vcoBand         <= 8'h80;
            bandBit_q       <= 8'h80;
          end
        end
        ST_CORE, ST_BAND: begin
          if (rcntTick_q) begin
            if (clkCnt_q == `SEL_STEP_CLKS - 5'h01) begin
              clkCnt_q <= 5'h00;
              step_q   <= step_q + 4'h1;
              if (state_q == ST_CORE) begin
                if (vcoSlow & (vcoCore != 2'h3)) begin
                  vcoCore <= vcoCore + 2'h1;
                end
                if (step_q == `SEL_CORE_STEPS - 4'h1) begin
                  state_q <= ST_BAND;
                end
              end else begin
                vcoBand <= (vcoSlow ? vcoBand : (vcoBand & ~bandBit_q))
                           | (bandBit_q >> 1);
                bandBit_q <= bandBit_q >> 1;
                if (step_q == `SEL_STEPS - 4'h1) begin
                  state_q <= ST_DONE;
                end
              end
            end else begin
              clkCnt_q <= clkCnt_q + 5'h01;
            end
          end
        end
        ST_DONE: begin
          tuningNodeToRef <= 1'b0;
          state_q         <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // fracn_pll_ctrl

// ===== testbench/fracn_pll_ctrl_asserts.sv
// Concurrent checks on the divider control block ports.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/1ps
`include "fracn_pll_ctrl_map.vh"
module fracn_pll_ctrl_asserts #(
  parameter [7:0] REVISION = `REV_DEFAULT
) (
  // Clock and reset
  input wire        clock,
  input wire        rst,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  // Reference and controls
  input wire        refPulse,
  input wire        refDiffMode,
  input wire        phaseDetectorClk,
  input wire        tuningNodeToRef,
  input wire        intMode,
  input wire [24:0] primaryFracActive,
  input wire [13:0] auxFracActive,
  input wire [13:0] auxModActive,
  input wire [3:0]  cpCurrent
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire wrDone = psel && penable && pwrite && pready;
  wire trig   = wrDone && paddr == `REG_TRIGGER_ADDR;
  reg  autoCal_q;
  reg  [7:0] searchTicks_q;
  // Mirrors the autocal enable so the search start can be predicted
  always @(posedge clock or posedge rst)
    if (rst) autoCal_q <= 1'b1;
    else if (wrDone && paddr == `REG_CTRL_ADDR) autoCal_q <= pwdata[`CTRL_AUTOCAL_BIT];
  // Detector pulses seen during one search; 11 steps of 16 ticks end it
  always @(posedge clock or posedge rst)
    if (rst) searchTicks_q <= 8'h00;
    else if (!tuningNodeToRef) searchTicks_q <= 8'h00;
    else if (phaseDetectorClk && searchTicks_q != 8'hFF) searchTicks_q <= searchTicks_q + 8'h01;
  sequence revRead;
    psel && !penable && !pwrite && paddr == `REG_REVISION_ADDR;
  endsequence
  sequence searchStart;
    $rose(tuningNodeToRef);
  endsequence
  a_ref_mode: assert property (wrDone && paddr == `REG_CTRL_ADDR |=> ##1
    refDiffMode == $past(pwdata[`CTRL_REFDIFF_BIT], 2)) else $error("reference mode not applied");
  a_shadow_hold: assert property (!trig |=> $stable(primaryFracActive) &&
    $stable(auxFracActive) && $stable(auxModActive) && $stable(cpCurrent))
    else $error("active setting changed without trigger");
  a_int_mode: assert property (
    intMode == (primaryFracActive == 25'h0 && auxFracActive == 14'h0))
    else $error("integer mode flag wrong");
  a_auxmod_floor: assert property (auxModActive >= `AUXMOD_MIN)
    else $error("auxiliary modulus below two");
  a_detclk_cause: assert property ($rose(phaseDetectorClk) |->
    $past(refPulse, 2) || $past(refPulse, 3)) else $error("detector pulse without reference");
  a_tune_start: assert property (trig && autoCal_q && !tuningNodeToRef |=> tuningNodeToRef)
    else $error("search did not start");
  a_tune_hold: assert property (searchStart |=> tuningNodeToRef [*8])
    else $error("search ended too soon");
  a_tune_end: assert property (tuningNodeToRef |-> searchTicks_q <= 8'hB1)
    else $error("search ran past its step count");
  a_rev_read: assert property (revRead |=> pready && prdata[7:0] == REVISION)
    else $error("revision read wrong");
endmodule // fracn_pll_ctrl_asserts
bind fracn_pll_ctrl fracn_pll_ctrl_asserts #(.REVISION(REVISION)) chk (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .refPulse(refPulse), .refDiffMode(refDiffMode), .phaseDetectorClk(phaseDetectorClk),
  .tuningNodeToRef(tuningNodeToRef), .intMode(intMode),
  .primaryFracActive(primaryFracActive), .auxFracActive(auxFracActive),
  .auxModActive(auxModActive), .cpCurrent(cpCurrent));

// ===== testbench/tb_top.sv
// Self-checking bench for the divider control block.
// Drives APB and the reference pulse itself; no far-side model.
`timescale 1ns/1ps
`include "fracn_pll_ctrl_map.vh"
module tb_top;
  logic        clock, rst, psel, penable, pwrite, refPulse, vcoSlow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, refDiffMode, sdmDisable, phaseDetectorClk;
  wire         tuningNodeToRef, intMode;
  wire  [15:0] intActive;
  wire  [24:0] primaryFracActive;
  wire  [13:0] auxFracActive, auxModActive;
  wire  [3:0]  cpCurrent;
  wire  [1:0]  vcoCore;
  wire  [7:0]  vcoBand;
  int          checks = 0, mismatches = 0, cnt, n;
  // Address, write data, expected read data, expected error
  logic [76:0] rows [0:9] = '{
    {12'h000, 32'h0000_0042, 32'h0000_0042, 1'b0},
    {12'h004, 32'hFFFF_0017, 32'h0000_0017, 1'b0},
    {12'h008, 32'h01FF_FFFF, 32'h01FF_FFFF, 1'b0},
    {12'h00C, 32'h0000_3FFF, 32'h0000_3FFF, 1'b0},
    {12'h010, 32'h0000_0001, 32'h0000_0002, 1'b0},
    {12'h010, 32'h0000_0600, 32'h0000_0600, 1'b0},
    {12'h014, 32'h0000_0F61, 32'h0000_0F61, 1'b0},
    {12'h024, 32'h0000_0009, 32'h0000_0001, 1'b0},
    {12'h020, 32'h0000_00FF, 32'h0000_005A, 1'b0},
    {12'h030, 32'h1234_5678, 32'h0000_0000, 1'b1}};
  logic [7:0]  refCfgRow [0:4] = '{8'h01, 8'h04, 8'h00, 8'h62, 8'h23};
  int          detPer [0:4] = '{2, 8, 64, 4, 3};
  fracn_pll_ctrl uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refPulse(refPulse), .vcoSlow(vcoSlow), .refDiffMode(refDiffMode),
    .sdmDisable(sdmDisable), .phaseDetectorClk(phaseDetectorClk),
    .tuningNodeToRef(tuningNodeToRef), .intMode(intMode), .intActive(intActive),
    .primaryFracActive(primaryFracActive), .auxFracActive(auxFracActive),
    .auxModActive(auxModActive), .cpCurrent(cpCurrent), .vcoCore(vcoCore), .vcoBand(vcoBand));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) refPulse <= ~refPulse;
  task check(input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request stands until pready is sampled high at a rising edge, then is released
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Registered controls follow a register write one edge later
  task settle;
    repeat (2) @(negedge clock);
  endtask
  task wait_det;
    n = 0;
    @(negedge clock);
    while (phaseDetectorClk !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (n >= 300) mismatches = mismatches + 1;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; refPulse = 1'b0; vcoSlow = 1'b0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check(intMode, 1);
    check(auxModActive, 2);
    check(vcoBand, 8'h80);
    check(intActive, 16'h0064);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, rows[i][76:65], rows[i][64:33]);
      apb(1'b0, rows[i][76:65], 32'h0);
      check(rd, rows[i][32:1]);
      check(err, rows[i][0]);
    end
    check(refDiffMode, 1);
    check(sdmDisable, 1);
    check(intActive, 16'h0017);
    check(primaryFracActive, 0);
    apb(1'b1, `REG_TRIGGER_ADDR, 32'h0);
    @(negedge clock);
    check(primaryFracActive, 25'h1FF_FFFF);
    check(auxFracActive, 14'h3FFF);
    check(auxModActive, 14'h0600);
    check(cpCurrent, 4'hF);
    check(intMode, 0);
    $display("register table test done");
    apb(1'b1, `REG_CTRL_ADDR, 32'h0);
    settle;
    check(refDiffMode, 0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `REG_REFCFG_ADDR, {24'h000000, refCfgRow[i]});
      apb(1'b1, `REG_TRIGGER_ADDR, 32'h0);
      wait_det;
      wait_det;
      cnt = 0;
      repeat (4 * detPer[i]) begin
        @(negedge clock);
        if (phaseDetectorClk === 1'b1) cnt++;
      end
      check(cnt, 4);
    end
    $display("reference path test done");
    vcoSlow <= 1'b1;
    apb(1'b1, `REG_CTRL_ADDR, 32'h1);
    apb(1'b1, `REG_REFCFG_ADDR, 32'h1);
    apb(1'b1, `REG_TRIGGER_ADDR, 32'h0);
    @(negedge clock);
    check(tuningNodeToRef, 1);
    n = 0;
    while (tuningNodeToRef !== 1'b0 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    check(tuningNodeToRef, 0);
    // 11 steps of 16 ticks, one tick per two cycles here
    check(n >= 340, 1);
    check({vcoCore, vcoBand}, 10'h3FF);
    $display("band search test done");
    apb(1'b1, `REG_PRIFRAC_ADDR, 32'h0);
    apb(1'b1, `REG_AUXFRAC_ADDR, 32'h0);
    apb(1'b1, `REG_CTRL_ADDR, 32'h2);
    settle;
    check(sdmDisable, 1);
    check(intMode, 0);
    apb(1'b1, `REG_TRIGGER_ADDR, 32'h0);
    @(negedge clock);
    check(intMode, 1);
    check(tuningNodeToRef, 0);
    $display("integer mode test done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check(auxModActive, 2);
    check(intMode, 1);
    check(refDiffMode, 0);
    check(cpCurrent, 0);
    $display("reset test done");
    report_and_stop;
  end
endmodule // tb_top
